//--- rtl/rsq_defines.svh
// offsets, field positions, reset values, voltage and timing constants of the sequencer
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define RSQ_OFS_SW1_VOLT 8'h07
`define RSQ_OFS_LIN0_CTRL 8'h08
`define RSQ_OFS_LIN1_CTRL 8'h09
`define RSQ_OFS_LIN0_VOLT 8'h0a
`define RSQ_OFS_LIN1_VOLT 8'h0b
`define RSQ_OFS_SW0_DELAY 8'h0c
`define RSQ_OFS_SW1_DELAY 8'h0d

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define RSQ_BIT_ON 0
`define RSQ_BIT_PIN_QUALIFY 1
`define RSQ_BIT_DISCHARGE 2
`define RSQ_RST_CTRL 8'h04
`define RSQ_RST_VOLT 8'h00
`define RSQ_RST_DELAY 8'h00
`define RSQ_CTRL_RSVD_MASK 8'h07
`define RSQ_LIN_VOLT_MASK 8'h1f

// ****************************************************************
// switcher setpoint bands (millivolts)
// ****************************************************************
`define RSQ_SW_BAND1_LO 8'h14
`define RSQ_SW_BAND2_LO 8'h18
`define RSQ_SW_BAND3_LO 8'h9e
`define RSQ_SW_BAND1_MV 12'h2bc
`define RSQ_SW_BAND2_MV 12'h2df
`define RSQ_SW_BAND3_MV 12'h58c
`define RSQ_SW_STEP1_MV 12'h00a
`define RSQ_SW_STEP2_MV 12'h005
`define RSQ_SW_STEP3_MV 12'h014

// ****************************************************************
// linear setpoint (millivolts)
// ****************************************************************
`define RSQ_LIN_TOP_CODE 5'h19
`define RSQ_LIN_BASE_MV 12'h320
`define RSQ_LIN_STEP_MV 12'h064

// ****************************************************************
// timing
// ****************************************************************
`define RSQ_CLK_PERIOD_NS 25
`define RSQ_DELAY_STEP_NS 500000
`define RSQ_STEP_CYCLES (`RSQ_DELAY_STEP_NS / `RSQ_CLK_PERIOD_NS)

`endif

//--- rtl/rsq_pkg.sv
// types shared by the sequencer modules
`default_nettype none
package rsq_pkg;
   typedef enum logic [3:0] {
      RSQ_GATE_OFF = 4'b0001,
      RSQ_GATE_RISE = 4'b0010,
      RSQ_GATE_ON = 4'b0100,
      RSQ_GATE_FALL = 4'b1000
   } rsq_gate_e;
   typedef logic [11:0] rsq_mv_t;
endpackage
`default_nettype wire

//--- rtl/rsq_seq_if.sv
// control and result of one switcher's delayed sequencing
`default_nettype none
interface rsq_seq_if;
   logic en_bit;
   logic qualify;
   logic [3:0] rise_wait;
   logic [3:0] fall_wait;
   logic rise_long;
   logic fall_long;
   logic run;
   modport ctrl (output en_bit, qualify, rise_wait, fall_wait, rise_long, fall_long, input run);
   modport timer (input en_bit, qualify, rise_wait, fall_wait, rise_long, fall_long, output run);
endinterface
`default_nettype wire

//--- rtl/rsq_seq_timer.sv
// startup and shutdown delay timer for one switcher
`default_nettype none
module rsq_seq_timer
   import rsq_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = 20000
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // synchronised enable pin
   input wire logic pin_level,
   // control and result
   rsq_seq_if.timer sif
);
   localparam int DW = $clog2(STEP_CYCLES + 1);

   if (STEP_CYCLES < 1) begin : g_bad_step
      $error("step length must be at least one cycle");
   end

   rsq_gate_e state_reg, state_next;
   logic [4:0] steps_reg, steps_next;
   logic [DW-1:0] div_reg, div_next;
   logic pin_prev_reg;
   logic tick;
   logic [4:0] rise_load;
   logic [4:0] fall_load;
   logic gate;

   // ****************************************************************
   // delay state machine
   // ****************************************************************
   always_comb begin
      // divider restarts on every entry to a wait, so the delay is exact
      tick = (div_reg == DW'(STEP_CYCLES - 1));
      rise_load = sif.rise_long ? {sif.rise_wait, 1'b0} : {1'b0, sif.rise_wait};
      fall_load = sif.fall_long ? {sif.fall_wait, 1'b0} : {1'b0, sif.fall_wait};
      state_next = state_reg;
      steps_next = steps_reg;
      div_next = tick ? '0 : DW'(div_reg + 1'b1);
      unique case (state_reg)
         RSQ_GATE_OFF: begin
            div_next = '0;
            if (pin_level && !pin_prev_reg) begin
               steps_next = rise_load;
               state_next = (rise_load == 5'h00) ? RSQ_GATE_ON : RSQ_GATE_RISE;
            end
         end
         RSQ_GATE_RISE: begin
            if (!pin_level) begin
               state_next = RSQ_GATE_OFF;
            end else if (tick) begin
               steps_next = 5'(steps_reg - 1'b1);
               if (steps_reg == 5'h01) begin
                  state_next = RSQ_GATE_ON;
               end
            end
         end
         RSQ_GATE_ON: begin
            div_next = '0;
            if (!pin_level && pin_prev_reg) begin
               steps_next = fall_load;
               state_next = (fall_load == 5'h00) ? RSQ_GATE_OFF : RSQ_GATE_FALL;
            end
         end
         RSQ_GATE_FALL: begin
            if (pin_level) begin
               state_next = RSQ_GATE_ON;
            end else if (tick) begin
               steps_next = 5'(steps_reg - 1'b1);
               if (steps_reg == 5'h01) begin
                  state_next = RSQ_GATE_OFF;
               end
            end
         end
         default: begin
            state_next = RSQ_GATE_OFF;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= RSQ_GATE_OFF;
         steps_reg <= 5'h00;
         div_reg <= '0;
         pin_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         steps_reg <= steps_next;
         div_reg <= div_next;
         pin_prev_reg <= pin_level;
      end
   end

   // software-only regulators bypass the delays entirely
   assign gate = (state_reg == RSQ_GATE_ON) || (state_reg == RSQ_GATE_FALL);
   assign sif.run = sif.qualify ? (sif.en_bit & gate) : sif.en_bit;
endmodule
`default_nettype wire

//--- rtl/rsq_sequencer.sv
// regulator enable sequencer: setpoint, control and delay registers, enable gating
`include "rsq_defines.svh"
`default_nettype none

module rsq_sequencer
   import rsq_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `RSQ_STEP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // external enable pin
   input wire logic en_pin,
   // switcher control bits held elsewhere
   input wire logic [1:0] sw_on,
   input wire logic [1:0] sw_pin_qualify,
   input wire logic rise_long,
   input wire logic fall_long,
   // regulator controls
   output logic [1:0] sw_run,
   output logic [1:0] lin_run,
   output logic [1:0] lin_discharge,
   // voltage targets in millivolts
   output logic [11:0] sw1_target_mv,
   output logic [11:0] lin0_target_mv,
   output logic [11:0] lin1_target_mv
);

   // ****************************************************************
   // setpoint decoding
   // ****************************************************************
   function automatic rsq_mv_t sw_code_mv(input logic [7:0] code);
      rsq_mv_t mv;
      mv = 12'h000; // reserved codes give no target
      if (code >= `RSQ_SW_BAND3_LO) begin
         mv = 12'(`RSQ_SW_BAND3_MV + 12'(code - `RSQ_SW_BAND3_LO) * `RSQ_SW_STEP3_MV);
      end else if (code >= `RSQ_SW_BAND2_LO) begin
         mv = 12'(`RSQ_SW_BAND2_MV + 12'(code - `RSQ_SW_BAND2_LO) * `RSQ_SW_STEP2_MV);
      end else if (code >= `RSQ_SW_BAND1_LO) begin
         mv = 12'(`RSQ_SW_BAND1_MV + 12'(code - `RSQ_SW_BAND1_LO) * `RSQ_SW_STEP1_MV);
      end
      return mv;
   endfunction

   function automatic rsq_mv_t lin_code_mv(input logic [7:0] code);
      rsq_mv_t mv;
      logic [4:0] c;
      c = code[4:0];
      mv = 12'h000;
      // reserved codes above the top give no target
      if (c <= `RSQ_LIN_TOP_CODE) begin
         mv = 12'(`RSQ_LIN_BASE_MV + 12'(c) * `RSQ_LIN_STEP_MV);
      end
      return mv;
   endfunction

   // ****************************************************************
   // pin synchroniser
   // ****************************************************************
   logic pin_meta_reg, pin_sync_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= en_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0] lin_ctrl_reg [2];
   logic [7:0] lin_ctrl_next [2];
   logic [7:0] lin_volt_reg [2];
   logic [7:0] lin_volt_next [2];
   logic [7:0] sw_delay_reg [2];
   logic [7:0] sw_delay_next [2];
   logic [7:0] sw1_volt_reg, sw1_volt_next;
   logic [7:0] rdata_next;

   always_comb begin
      lin_ctrl_next = lin_ctrl_reg;
      lin_volt_next = lin_volt_reg;
      sw_delay_next = sw_delay_reg;
      sw1_volt_next = sw1_volt_reg;
      if (reg_wr) begin
         unique case (reg_addr)
            `RSQ_OFS_SW1_VOLT: sw1_volt_next = reg_wdata;
            // reserved control bits are kept at zero
            `RSQ_OFS_LIN0_CTRL: lin_ctrl_next[0] = reg_wdata & `RSQ_CTRL_RSVD_MASK;
            `RSQ_OFS_LIN1_CTRL: lin_ctrl_next[1] = reg_wdata & `RSQ_CTRL_RSVD_MASK;
            `RSQ_OFS_LIN0_VOLT: lin_volt_next[0] = reg_wdata & `RSQ_LIN_VOLT_MASK;
            `RSQ_OFS_LIN1_VOLT: lin_volt_next[1] = reg_wdata & `RSQ_LIN_VOLT_MASK;
            `RSQ_OFS_SW0_DELAY: sw_delay_next[0] = reg_wdata;
            `RSQ_OFS_SW1_DELAY: sw_delay_next[1] = reg_wdata;
            default: begin
            end
         endcase
      end
      unique case (reg_addr)
         `RSQ_OFS_SW1_VOLT: rdata_next = sw1_volt_reg;
         `RSQ_OFS_LIN0_CTRL: rdata_next = lin_ctrl_reg[0];
         `RSQ_OFS_LIN1_CTRL: rdata_next = lin_ctrl_reg[1];
         `RSQ_OFS_LIN0_VOLT: rdata_next = lin_volt_reg[0];
         `RSQ_OFS_LIN1_VOLT: rdata_next = lin_volt_reg[1];
         `RSQ_OFS_SW0_DELAY: rdata_next = sw_delay_reg[0];
         `RSQ_OFS_SW1_DELAY: rdata_next = sw_delay_reg[1];
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lin_ctrl_reg[0] <= `RSQ_RST_CTRL;
         lin_ctrl_reg[1] <= `RSQ_RST_CTRL;
         lin_volt_reg[0] <= `RSQ_RST_VOLT;
         lin_volt_reg[1] <= `RSQ_RST_VOLT;
         sw_delay_reg[0] <= `RSQ_RST_DELAY;
         sw_delay_reg[1] <= `RSQ_RST_DELAY;
         sw1_volt_reg <= `RSQ_RST_VOLT;
         reg_rdata <= 8'h00;
      end else begin
         lin_ctrl_reg <= lin_ctrl_next;
         lin_volt_reg <= lin_volt_next;
         sw_delay_reg <= sw_delay_next;
         sw1_volt_reg <= sw1_volt_next;
         reg_rdata <= rdata_next;
      end
   end

   // ****************************************************************
   // switcher delayed sequencing
   // ****************************************************************
   logic [1:0] sw_run_raw;

   for (genvar i = 0; i < 2; i++) begin : g_sw
      rsq_seq_if sif ();

      // each switcher reads only its own delay register
      assign sif.en_bit = sw_on[i];
      assign sif.qualify = sw_pin_qualify[i];
      assign sif.rise_wait = sw_delay_reg[i][3:0];
      assign sif.fall_wait = sw_delay_reg[i][7:4];
      assign sif.rise_long = rise_long;
      assign sif.fall_long = fall_long;
      assign sw_run_raw[i] = sif.run;

      rsq_seq_timer #(
         .STEP_CYCLES(STEP_CYCLES)
      ) u_timer (
         .clk(clk),
         .srst(srst),
         .pin_level(pin_sync_reg),
         .sif(sif)
      );
   end

   // ****************************************************************
   // linear regulators and outputs
   // ****************************************************************
   logic [1:0] lin_run_next;
   logic [1:0] lin_dis_next;

   always_comb begin
      for (int k = 0; k < 2; k++) begin
         // linear regulators have no delay register here, so they gate at once
         lin_run_next[k] = lin_ctrl_reg[k][`RSQ_BIT_ON] &
            (~lin_ctrl_reg[k][`RSQ_BIT_PIN_QUALIFY] | pin_sync_reg);
         lin_dis_next[k] = ~lin_run_next[k] & lin_ctrl_reg[k][`RSQ_BIT_DISCHARGE];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sw_run <= 2'h0;
         lin_run <= 2'h0;
         lin_discharge <= 2'h0;
         sw1_target_mv <= 12'h000;
         lin0_target_mv <= 12'h000;
         lin1_target_mv <= 12'h000;
      end else begin
         sw_run <= sw_run_raw;
         lin_run <= lin_run_next;
         lin_discharge <= lin_dis_next;
         sw1_target_mv <= sw_code_mv(sw1_volt_reg);
         lin0_target_mv <= lin_code_mv(lin_volt_reg[0]);
         lin1_target_mv <= lin_code_mv(lin_volt_reg[1]);
      end
   end

endmodule
`default_nettype wire

//--- bench/rsq_sequencer_props.sv
// assertion checker for the regulator enable sequencer
`default_nettype none
module rsq_sequencer_props #(
   parameter int unsigned STEP_CYCLES = 20000
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // pin and switcher controls
   input wire logic en_pin,
   input wire logic [1:0] sw_on,
   input wire logic [1:0] sw_pin_qualify,
   input wire logic rise_long,
   input wire logic fall_long,
   // regulator outputs
   input wire logic [1:0] sw_run,
   input wire logic [1:0] lin_run,
   input wire logic [1:0] lin_discharge,
   input wire logic [11:0] sw1_target_mv,
   input wire logic [11:0] lin0_target_mv,
   input wire logic [11:0] lin1_target_mv
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // properties
   // *****
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   function automatic logic [11:0] sw_mv(input logic [7:0] c);
      if (c >= 8'h9e) return 12'h58c + 12'h014 * 12'(c - 8'h9e);
      if (c >= 8'h18) return 12'h2df + 12'h005 * 12'(c - 8'h18);
      if (c >= 8'h14) return 12'h2bc + 12'h00a * 12'(c - 8'h14);
      return 12'h000;
   endfunction

   sequence wr_then_rd;
      reg_wr && (reg_addr == 8'h07 || reg_addr == 8'h0c || reg_addr == 8'h0d) ##1
      !reg_wr && reg_addr == $past(reg_addr);
   endsequence
   // three quiet cycles so the registered target has caught up
   sequence quiet_rd(logic [7:0] a);
      !reg_wr [*3] ##0 reg_addr == a;
   endsequence

   byte_readback_a: assert property (wr_then_rd |=> reg_rdata == $past(reg_wdata, 2))
      else $error("register readback mismatch");
   ctrl_rsvd_a: assert property (reg_addr == 8'h08 || reg_addr == 8'h09 |=> reg_rdata[7:3] == 5'h00)
      else $error("control reserved bits set");
   volt_rsvd_a: assert property (reg_addr == 8'h0a || reg_addr == 8'h0b |=> reg_rdata[7:5] == 3'h0)
      else $error("linear voltage reserved bits set");
   lin_target_a: assert property (quiet_rd(8'h0a) |=> lin0_target_mv ==
      ((reg_rdata[4:0] <= 5'h19) ? 12'h320 + 12'h064 * 12'(reg_rdata[4:0]) : 12'h000))
      else $error("linear target mismatch");
   lin1_target_a: assert property (quiet_rd(8'h0b) |=> lin1_target_mv ==
      ((reg_rdata[4:0] <= 5'h19) ? 12'h320 + 12'h064 * 12'(reg_rdata[4:0]) : 12'h000))
      else $error("second linear target mismatch");
   sw_target_a: assert property (quiet_rd(8'h07) |=> sw1_target_mv == sw_mv(reg_rdata))
      else $error("switcher target mismatch");
   no_dis_run_a: assert property ((lin_discharge & lin_run) == 2'b00)
      else $error("discharge while running");
   sw_follow_a: assert property (!$past(srst) && sw_pin_qualify == 2'b00 &&
      $past(sw_pin_qualify) == 2'b00 |-> sw_run == $past(sw_on))
      else $error("unqualified switcher not following enable");
   run_cause_a: assert property ($rose(sw_run[1]) |-> $past(sw_on[1]))
      else $error("switcher started without enable bit");
endmodule

bind rsq_sequencer rsq_sequencer_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
   .clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .en_pin, .sw_on,
   .sw_pin_qualify, .rise_long, .fall_long, .sw_run, .lin_run, .lin_discharge,
   .sw1_target_mv, .lin0_target_mv, .lin1_target_mv
);
`default_nettype wire

//--- bench/rsq_sequencer_tb.sv
// self-checking bench for the regulator enable sequencer
`default_nettype none
module rsq_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // stimulus and dut
   // *****
   localparam int STEP = 4;
   // zero-delay lag: two pin flops, timer state, output register
   localparam int LAG = 4;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic en_pin = 1'b0;
   logic [1:0] sw_on = 2'b00;
   logic [1:0] sw_pin_qualify = 2'b00;
   logic rise_long = 1'b0;
   logic fall_long = 1'b0;
   wire logic [7:0] reg_rdata;
   wire logic [1:0] sw_run;
   wire logic [1:0] lin_run;
   wire logic [1:0] lin_discharge;
   wire logic [11:0] sw1_target_mv;
   wire logic [11:0] lin0_target_mv;
   wire logic [11:0] lin1_target_mv;
   int num_errors = 0;
   int samples_checked = 0;
   int base_r;
   int base_f;

   rsq_sequencer #(.STEP_CYCLES(STEP)) dut (
      .clk, .srst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .en_pin, .sw_on,
      .sw_pin_qualify, .rise_long, .fall_long, .sw_run, .lin_run, .lin_discharge,
      .sw1_target_mv, .lin0_target_mv, .lin1_target_mv
   );

   initial begin
      forever #12.5 clk = ~clk;
   end

   // *****
   // helpers
   // *****
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk_val(input string n, input logic [11:0] e, input logic [11:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_bits(input string n, input logic [1:0] e, input logic [1:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %b seen %b", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // strobe drops a full cycle before the next write may raise it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      cyc(1);
      chk_val("register", {4'h0, e}, {4'h0, reg_rdata});
   endtask

   // cycles until each switcher reaches lvl, -1 if never
   task automatic meas(output int t0, output int t1, input logic lvl);
      t0 = -1;
      t1 = -1;
      for (int n = 1; n < 160; n++) begin
         cyc(1);
         if (t0 < 0 && sw_run[0] === lvl) t0 = n;
         if (t1 < 0 && sw_run[1] === lvl) t1 = n;
      end
   endtask

   // *****
   // scenarios
   // *****
   task automatic t_reset;
      chk_bits("discharge", 2'b11, lin_discharge);
      rd(8'h08, 8'h04);
      rd(8'h09, 8'h04);
      rd(8'h0b, 8'h00);
      rd(8'h0d, 8'h00);
      rd(8'h20, 8'h00);
   endtask

   task automatic t_regs;
      wr(8'h08, 8'hf8);
      rd(8'h08, 8'h00);
      chk_bits("discharge", 2'b10, lin_discharge);
      wr(8'h0b, 8'he9);
      rd(8'h0b, 8'h09);
      wr(8'h20, 8'h55);
      rd(8'h20, 8'h00);
   endtask

   task automatic t_volt;
      logic [7:0] sc [6] = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};
      logic [11:0] sm [6] = '{12'h2bc, 12'h2da, 12'h2df, 12'h578, 12'h58c, 12'hd20};
      for (int i = 0; i < 6; i++) begin
         wr(8'h07, sc[i]);
         cyc(2);
         chk_val("switcher mv", sm[i], sw1_target_mv);
      end
      wr(8'h0a, 8'h19);
      cyc(2);
      wr(8'h0b, 8'h00);
      cyc(2);
      chk_val("lin0 mv", 12'hce4, lin0_target_mv);
      chk_val("lin1 mv", 12'h320, lin1_target_mv);
   endtask

   task automatic t_linear;
      wr(8'h08, 8'h01);
      cyc(2);
      chk_bits("lin run", 2'b01, lin_run);
      chk_bits("discharge", 2'b10, lin_discharge);
      wr(8'h08, 8'h07);
      cyc(2);
      chk_bits("lin run", 2'b00, lin_run);
      chk_bits("discharge", 2'b11, lin_discharge);
      en_pin = 1'b1;
      cyc(5);
      chk_bits("lin run", 2'b01, lin_run);
      en_pin = 1'b0;
      wr(8'h08, 8'h02);
      cyc(5);
      chk_bits("discharge", 2'b10, lin_discharge);
   endtask

   task automatic t_plain;
      sw_on = 2'b10;
      cyc(2);
      chk_bits("switcher run", 2'b10, sw_run);
      sw_on = 2'b01;
      cyc(1);
      chk_bits("switcher run", 2'b01, sw_run);
   endtask

   // steps are expected extra cycles beyond zero delay, in units of STEP
   task automatic t_seq(input logic [7:0] d0, input logic [7:0] d1, input logic rl,
      input logic fl, input int r0, input int r1, input int f0, input int f1);
      int t0, t1;
      wr(8'h0c, d0);
      wr(8'h0d, d1);
      rise_long = rl;
      fall_long = fl;
      en_pin = 1'b1;
      meas(t0, t1, 1'b1);
      chk_val("rise lag 0", 12'(LAG + r0 * STEP), 12'(t0));
      chk_val("rise lag 1", 12'(LAG + r1 * STEP), 12'(t1));
      en_pin = 1'b0;
      meas(t0, t1, 1'b0);
      chk_val("fall lag 0", 12'(LAG + f0 * STEP), 12'(t0));
      chk_val("fall lag 1", 12'(LAG + f1 * STEP), 12'(t1));
   endtask

   task automatic t_delay;
      int b1;
      sw_on = 2'b11;
      sw_pin_qualify = 2'b11;
      cyc(2);
      en_pin = 1'b1;
      meas(base_r, b1, 1'b1);
      chk_val("zero rise 0", 12'(LAG), 12'(base_r));
      chk_val("zero rise 1", 12'(LAG), 12'(b1));
      en_pin = 1'b0;
      meas(base_f, b1, 1'b0);
      chk_val("zero fall 0", 12'(LAG), 12'(base_f));
      chk_val("zero fall 1", 12'(LAG), 12'(b1));
      t_seq(8'h21, 8'h03, 1'b0, 1'b1, 1, 3, 4, 0);
      t_seq(8'hf1, 8'h0f, 1'b1, 1'b0, 2, 30, 15, 0);
   endtask

   task automatic t_cancel;
      int t0, t1;
      wr(8'h0c, 8'h0f);
      rise_long = 1'b0;
      en_pin = 1'b1;
      cyc(30);
      en_pin = 1'b0;
      meas(t0, t1, 1'b1);
      chk_val("cancel 0", 12'hfff, 12'(t0));
      chk_val("cancel 1", 12'hfff, 12'(t1));
      // pin returns high inside the shutdown wait: switcher 0 must stay on
      wr(8'h0c, 8'hf0);
      en_pin = 1'b1;
      cyc(10);
      en_pin = 1'b0;
      cyc(30);
      en_pin = 1'b1;
      meas(t0, t1, 1'b0);
      chk_val("cancel fall", 12'hfff, 12'(t0));
   endtask

   initial begin
      cyc(6);
      srst = 1'b0;
      cyc(1);
      t_reset();
      t_regs();
      t_volt();
      t_linear();
      t_plain();
      t_delay();
      t_cancel();
      finish_test();
   end

   // whole run needs about 1500 cycles; double that is a hang
   initial begin
      cyc(3000);
      num_errors++;
      $display("watchdog expired");
      finish_test();
   end
endmodule
`default_nettype wire
